// ===== hdl/hhe_engine.sv
/*
 * Keyed-hash engine control: registers, flags, key handling,
 * block intake with optional padding and a compact mixing core.
 * Assumes the controller drives the link on the same clock.
 */
// The strobed register port and the register offsets were left to the implementer.
// Overview of operation
// - host writes byte length, 64-aligned unless closing
// - length write starts the operation
// - context-ready flag when inputs accept new context
// - partial flag after key context switch
// - input-ready flag when block buffer is free
// - output-ready flag when digest is final
// - per-source enables gate interrupt line
// - raw and masked status both readable
// - software clears any flag combination
// - config bit soft-resets the engine except the dma enable
// - dma requests only while enabled
// - key is sixteen zero-padded words
// - raw key is preprocessed before data
// - preprocessed key skips preprocessing
// - host checks context ready before key
// - digest length follows algorithm
// - keyed digest uses preprocessed key state
// - mode picks algorithm and plain/keyed
// - data enters in sixteen-word blocks
module hhe_engine (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// register link
	hhe_link_if.dev   link,
	// status
	output logic      busy_out
);
	import hhe_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_KEY,
		ST_WAIT,
		ST_RUN
	} hhe_eng_st_t;

	hhe_eng_st_t              st_ff;
	logic [MODE_W-1:0]        mode_ff;
	logic [31:0]              rem_ff;
	logic [31:0]              tot_ff;
	logic [NFLAG-1:0]         raw_ff;
	logic [NFLAG-1:0]         en_ff;
	logic                     dma_en_ff;
	logic                     srst_ff;
	logic                     pp_ff;
	logic                     boot_ff;
	logic [4:0]               cnt_ff;
	logic [31:0]              key_ff [KEY_WORDS];
	logic [31:0]              blk_ff [BLK_WORDS];
	logic [DIG_MAX-1:0][31:0] dig_ff;
	logic [31:0]              rdata_ff;
	logic                     irq_ff;
	logic                     dma_ff;
	logic                     busy_ff;
	logic                     rst;
	logic                     wr_len;
	logic                     wr_data;
	logic                     wr_key;
	logic                     skip_key;
	logic                     run_end;
	logic                     key_end;
	logic [31:0]              rem_nxt;
	logic [31:0]              word;
	logic [NFLAG-1:0]         set;
	logic [NFLAG-1:0]         clr;
	logic [3:0]               dlen;
	logic [DIG_MAX-1:0][31:0] kmix;

	// ----------------------------------------------------------
	// mixing helpers
	// ----------------------------------------------------------
	function automatic logic [DIG_MAX-1:0][31:0] hhe_round(
		input logic [DIG_MAX-1:0][31:0] s,
		input logic [31:0]              w,
		input logic [4:0]               i);
		logic [31:0] f;
		f = {s[7][26:0], s[7][31:27]} + (s[0] ^ s[4]) + w + {27'h0, i};
		hhe_round = {s[6:0], f};
	endfunction : hhe_round

	function automatic logic [31:0] hhe_pad(
		input logic [31:0] w,
		input logic [3:0]  j,
		input logic [31:0] rem,
		input logic [31:0] tot);
		logic [31:0] r;
		logic [31:0] pos;
		r = w;
		for (int b = 0; b < 4; b++) begin
			pos = {26'h0, j, 2'(b)};
			if (pos == rem)
				r[8*b +: 8] = 8'h80;
			else if (pos > rem)
				r[8*b +: 8] = 8'h00;
		end
		if (j == 4'hf && rem < PAD_ROOM)
			r = {tot[28:0], 3'h0};
		hhe_pad = r;
	endfunction : hhe_pad

	// ----------------------------------------------------------
	// decode
	// ----------------------------------------------------------
	// soft reset path
	assign rst      = !resetn_in || srst_ff;
	assign wr_len   = link.wr && link.addr == REG_LENGTH;
	assign wr_data  = link.wr && link.addr[5:4] == REG_DATA[5:4];
	assign wr_key   = link.wr && link.addr[5:4] == REG_DIGEST[5:4];
	assign skip_key = mode_ff[MODE_PPKEY] || pp_ff;
	assign run_end  = st_ff == ST_RUN && cnt_ff == 5'(ROUNDS - 1);
	assign key_end  = st_ff == ST_KEY && cnt_ff == 5'(ROUNDS - 1);
	assign rem_nxt  = rem_ff > BLK_BYTES ? rem_ff - BLK_BYTES : 32'h0;
	assign dlen     = hhe_dlen(mode_ff[1:0]);
	assign kmix     = hhe_round(dig_ff, key_ff[15] ^ IPAD, cnt_ff);
	assign clr      = (link.wr && link.addr == REG_RAW) ?
	                  link.wdata[NFLAG-1:0] : '0;

	always_comb begin
		word = blk_ff[cnt_ff[3:0]];
		if (mode_ff[MODE_CLOSE] && rem_ff < BLK_BYTES)
			word = hhe_pad(blk_ff[cnt_ff[3:0]], cnt_ff[3:0], rem_ff, tot_ff);
	end

	// ----------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst) begin
			st_ff  <= ST_IDLE;
			cnt_ff <= 5'h0;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (wr_len) begin
						cnt_ff <= 5'h0;
						if (mode_ff[MODE_HMAC] && !skip_key)
							st_ff <= ST_KEY;
						else
							st_ff <= ST_WAIT;
					end
				end
				ST_KEY: begin
					cnt_ff <= cnt_ff + 5'h1;
					if (key_end) begin
						cnt_ff <= 5'h0;
						st_ff  <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (wr_data) begin
						cnt_ff <= cnt_ff + 5'h1;
						if (cnt_ff == 5'(BLK_WORDS - 1)) begin
							cnt_ff <= 5'h0;
							st_ff  <= ST_RUN;
						end
					end
				end
				ST_RUN: begin
					cnt_ff <= cnt_ff + 5'h1;
					if (run_end) begin
						cnt_ff <= 5'h0;
						if (rem_nxt != 32'h0)
							st_ff <= ST_WAIT;
						else if (mode_ff[MODE_CLOSE] && rem_ff == BLK_BYTES)
							st_ff <= ST_RUN;
						else
							st_ff <= ST_IDLE;
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------
	// context: mode, length, key, data, digest
	// ----------------------------------------------------------
	// mode register
	always_ff @(posedge clk_in) begin
		if (rst)
			mode_ff <= '0;
		else if (link.wr && link.addr == REG_MODE && st_ff == ST_IDLE)
			mode_ff <= link.wdata[MODE_W-1:0];
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			rem_ff <= 32'h0;
			tot_ff <= 32'h0;
		end else if (wr_len && st_ff == ST_IDLE) begin
			rem_ff <= link.wdata;
			tot_ff <= link.wdata;
		end else if (run_end) begin
			rem_ff <= rem_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			pp_ff <= 1'b0;
			for (int k = 0; k < KEY_WORDS; k++)
				key_ff[k] <= 32'h0;
		end else if (wr_key && st_ff == ST_IDLE) begin
			key_ff[link.addr[3:0]] <= link.wdata;
			pp_ff                  <= 1'b0;
		end else if (key_end) begin
			for (int k = 0; k < DIG_MAX; k++)
				key_ff[k] <= kmix[k];
			pp_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			for (int k = 0; k < BLK_WORDS; k++)
				blk_ff[k] <= 32'h0;
		end else if (wr_data && st_ff == ST_WAIT) begin
			blk_ff[link.addr[3:0]] <= link.wdata;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			dig_ff <= '0;
		end else if (wr_len && st_ff == ST_IDLE) begin
			for (int k = 0; k < DIG_MAX; k++)
				dig_ff[k] <= IV_BASE + 32'(k);
			// keyed run starts from preprocessed key
			if (mode_ff[MODE_HMAC] && skip_key)
				for (int k = 0; k < DIG_MAX; k++)
					dig_ff[k] <= key_ff[k];
		end else if (st_ff == ST_KEY) begin
			dig_ff <= hhe_round(dig_ff, key_ff[cnt_ff[3:0]] ^ IPAD,
			                    cnt_ff);
		end else if (st_ff == ST_RUN) begin
			dig_ff <= hhe_round(dig_ff, word, cnt_ff);
		end
	end

	// ----------------------------------------------------------
	// flags, enables, config
	// ----------------------------------------------------------
	always_comb begin
		set = '0;
		set[FLG_CTX]  = boot_ff || (run_end && st_ff == ST_RUN &&
		                rem_nxt == 32'h0 &&
		                !(mode_ff[MODE_CLOSE] && rem_ff == BLK_BYTES));
		set[FLG_PART] = key_end;
		// block buffer free
		// raw key run: buffer opens only after preprocessing
		set[FLG_MSG]  = (st_ff == ST_IDLE && wr_len &&
		                 !(mode_ff[MODE_HMAC] && !skip_key)) ||
		                key_end || (run_end && rem_nxt != 32'h0);
		set[FLG_OUT]  = set[FLG_CTX] && !boot_ff;
	end

	always_ff @(posedge clk_in) begin
		if (rst)
			boot_ff <= 1'b1;
		else
			boot_ff <= 1'b0;
	end

	always_ff @(posedge clk_in) begin
		if (rst)
			raw_ff <= '0;
		else
			raw_ff <= (raw_ff & ~clr) | set;
	end

	always_ff @(posedge clk_in) begin
		if (rst)
			en_ff <= '0;
		else if (link.wr && link.addr == REG_IRQ_EN)
			en_ff <= link.wdata[NFLAG-1:0];
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			srst_ff   <= 1'b0;
			dma_en_ff <= 1'b0;
		end else begin
			srst_ff <= link.wr && link.addr == REG_SYSCFG &&
			           link.wdata[CFG_SRST];
			if (link.wr && link.addr == REG_SYSCFG)
				dma_en_ff <= link.wdata[CFG_DMA];
		end
	end

	// ----------------------------------------------------------
	// link answers
	// ----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst) begin
			irq_ff  <= 1'b0;
			dma_ff  <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			irq_ff  <= |(raw_ff & en_ff);
			dma_ff  <= dma_en_ff && st_ff == ST_WAIT;
			busy_ff <= st_ff != ST_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst) begin
			rdata_ff <= 32'h0;
		end else if (link.rd) begin
			rdata_ff <= 32'h0;
			case (link.addr)
				REG_MODE:   rdata_ff <= {27'h0, mode_ff};
				REG_LENGTH: rdata_ff <= rem_ff;
				REG_RAW:    rdata_ff <= {28'h0, raw_ff};
				REG_MASKED: rdata_ff <= {28'h0, raw_ff & en_ff};
				REG_IRQ_EN: rdata_ff <= {28'h0, en_ff};
				REG_SYSCFG: rdata_ff <= {30'h0, dma_en_ff, 1'b0};
				default: begin
					if (link.addr < {2'h0, dlen})
						rdata_ff <= dig_ff[link.addr[2:0]];
				end
			endcase
		end
	end

	assign link.rdata   = rdata_ff;
	assign link.irq     = irq_ff;
	assign link.dma_req = dma_ff;
	assign busy_out     = busy_ff;
endmodule : hhe_engine

// ===== hdl/hhe_host.sv
/*
 * Controller end: takes one job from software registers, drives
 * the engine over the link, services its flags, keeps the digest.
 * Assumes single-block messages of at most 64 bytes.
 */
module hhe_host (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// software port
	input  wire logic [5:0]  cmd_addr_in,
	input  wire logic [31:0] cmd_wdata_in,
	input  wire logic        cmd_wr_in,
	input  wire logic        cmd_rd_in,
	output logic      [31:0] cmd_rdata_out,
	// engine link
	hhe_link_if.host         link
);
	import hhe_pkg::*;

	localparam logic [5:0] H_MODE = 6'h00;
	localparam logic [5:0] H_LEN  = 6'h01;
	localparam logic [5:0] H_CTRL = 6'h02;
	localparam logic [5:0] H_STAT = 6'h03;

	typedef enum logic [3:0] {
		HS_IDLE, HS_RST, HS_EN, HS_MODE, HS_KEY, HS_LEN, HS_DATA,
		HS_RD, HS_WAIT, HS_POLL, HS_CHK, HS_GET, HS_CAP, HS_GAP, HS_GWT
	} hhe_host_st_t;

	hhe_host_st_t      st_ff;
	hhe_host_st_t      ret_ff;
	logic [MODE_W-1:0] mode_ff;
	logic [31:0]       len_ff;
	logic              dma_ff;
	logic              busy_ff;
	logic              done_ff;
	logic              err_ff;
	logic [NFLAG-1:0]  want_ff;
	logic [4:0]        cnt_ff;
	logic [31:0]       key_ff [KEY_WORDS];
	logic [31:0]       dat_ff [BLK_WORDS];
	logic [31:0]       res_ff [DIG_MAX];
	logic [5:0]        addr_ff;
	logic [31:0]       wdata_ff;
	logic              wr_ff;
	logic              rd_ff;
	logic [31:0]       rdata_ff;
	logic              start;

	assign start = cmd_wr_in && cmd_addr_in == H_CTRL && cmd_wdata_in[0];

	// ----------------------------------------------------------
	// software registers
	// ----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			mode_ff <= '0;
			len_ff  <= 32'h0;
			dma_ff  <= 1'b0;
		end else if (cmd_wr_in && st_ff == HS_IDLE) begin
			if (cmd_addr_in == H_MODE)
				mode_ff <= cmd_wdata_in[MODE_W-1:0];
			if (cmd_addr_in == H_LEN)
				len_ff <= cmd_wdata_in;
			if (cmd_addr_in == H_CTRL)
				dma_ff <= cmd_wdata_in[1];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			for (int k = 0; k < KEY_WORDS; k++) begin
				key_ff[k] <= 32'h0;
				dat_ff[k] <= 32'h0;
			end
		end else if (cmd_wr_in && st_ff == HS_IDLE) begin
			if (cmd_addr_in[5:4] == 2'h1)
				key_ff[cmd_addr_in[3:0]] <= cmd_wdata_in;
			if (cmd_addr_in[5:4] == 2'h2)
				dat_ff[cmd_addr_in[3:0]] <= cmd_wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rdata_ff <= 32'h0;
		end else if (cmd_rd_in) begin
			rdata_ff <= 32'h0;
			if (cmd_addr_in == H_STAT)
				rdata_ff <= {29'h0, err_ff, done_ff, busy_ff};
			else if (cmd_addr_in[5:3] == 3'h6)
				rdata_ff <= res_ff[cmd_addr_in[2:0]];
		end
	end

	// ----------------------------------------------------------
	// job sequencer
	// ----------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			st_ff    <= HS_IDLE;
			ret_ff   <= HS_IDLE;
			want_ff  <= '0;
			cnt_ff   <= 5'h0;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
			err_ff   <= 1'b0;
			addr_ff  <= 6'h0;
			wdata_ff <= 32'h0;
			wr_ff    <= 1'b0;
			rd_ff    <= 1'b0;
			for (int k = 0; k < DIG_MAX; k++)
				res_ff[k] <= 32'h0;
		end else begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			case (st_ff)
				HS_IDLE: begin
					if (start) begin
						done_ff <= 1'b0;
						err_ff  <= len_ff > BLK_BYTES || len_ff == 32'h0 ||
						           (!mode_ff[MODE_CLOSE] && len_ff[5:0] != 6'h0);
						if (!(len_ff > BLK_BYTES || len_ff == 32'h0 ||
						      (!mode_ff[MODE_CLOSE] && len_ff[5:0] != 6'h0))) begin
							busy_ff <= 1'b1;
							st_ff   <= HS_RST;
						end
					end
				end
				HS_RST: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_SYSCFG;
					wdata_ff <= 32'h1;
					st_ff    <= HS_GAP;
				end
				// soft reset edge would swallow the next write
				HS_GAP: st_ff <= HS_EN;
				HS_EN: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_IRQ_EN;
					wdata_ff <= 32'hd;
					want_ff  <= 4'h1;
					ret_ff   <= HS_MODE;
					st_ff    <= HS_WAIT;
				end
				HS_MODE: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_MODE;
					wdata_ff <= {27'h0, mode_ff};
					cnt_ff   <= 5'h0;
					st_ff    <= mode_ff[MODE_HMAC] ? HS_KEY : HS_LEN;
				end
				HS_KEY: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_DIGEST + {2'h0, cnt_ff[3:0]};
					wdata_ff <= key_ff[cnt_ff[3:0]];
					cnt_ff   <= cnt_ff + 5'h1;
					if (cnt_ff == 5'(KEY_WORDS - 1))
						st_ff <= HS_LEN;
				end
				HS_LEN: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_LENGTH;
					wdata_ff <= len_ff;
					want_ff  <= 4'h4;
					ret_ff   <= HS_DATA;
					cnt_ff   <= 5'h0;
					st_ff    <= HS_WAIT;
				end
				HS_DATA: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_DATA + {2'h0, cnt_ff[3:0]};
					wdata_ff <= dat_ff[cnt_ff[3:0]];
					cnt_ff   <= cnt_ff + 5'h1;
					if (cnt_ff == 5'(BLK_WORDS - 1)) begin
						want_ff <= 4'h8;
						ret_ff  <= HS_GET;
						st_ff   <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					if (link.irq)
						st_ff <= HS_POLL;
				end
				HS_POLL: begin
					rd_ff   <= 1'b1;
					addr_ff <= REG_MASKED;
					st_ff   <= HS_RD;
				end
				HS_RD: st_ff <= HS_CHK;
				HS_GWT: st_ff <= HS_CAP;
				HS_CHK: begin
					wr_ff    <= 1'b1;
					addr_ff  <= REG_RAW;
					wdata_ff <= link.rdata;
					cnt_ff   <= 5'h0;
					st_ff    <= |(link.rdata[NFLAG-1:0] & want_ff) ?
					            ret_ff : HS_WAIT;
				end
				HS_GET: begin
					rd_ff   <= 1'b1;
					addr_ff <= REG_DIGEST + {2'h0, cnt_ff[3:0]};
					st_ff   <= HS_GWT;
				end
				HS_CAP: begin
					if (cnt_ff < 5'(DIG_MAX))
						res_ff[cnt_ff[2:0]] <= link.rdata;
					cnt_ff <= cnt_ff + 5'h1;
					st_ff  <= HS_GET;
					if (cnt_ff == 5'(DIG_MAX - 1)) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
						st_ff   <= HS_IDLE;
					end
				end
				default: st_ff <= HS_IDLE;
			endcase
		end
	end

	assign link.addr     = addr_ff;
	assign link.wdata    = wdata_ff | {30'h0, dma_ff && addr_ff == REG_SYSCFG,
	                                   1'b0};
	assign link.wr       = wr_ff;
	assign link.rd       = rd_ff;
	assign cmd_rdata_out = rdata_ff;
endmodule : hhe_host

// ===== hdl/hhe_link_if.sv
/*
 * Register link between the engine and its controller.
 * Assumes one clock; read data follows a read strobe by one cycle.
 */
interface hhe_link_if (
	input wire logic clk_in
);
	logic [5:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        irq;
	logic        dma_req;

	modport dev (
		input  addr, wdata, wr, rd,
		output rdata, irq, dma_req
	);
	modport host (
		output addr, wdata, wr, rd,
		input  rdata, irq, dma_req
	);
endinterface : hhe_link_if

// ===== hdl/hhe_pkg.sv
/*
 * Shared constants for the keyed-hash engine and its controller:
 * link register indices, field positions, flag bits, block sizes.
 * Assumes both ends and the link interface compile after it.
 */
package hhe_pkg;
	// ----------------------------------------------------------
	// link geometry
	// ----------------------------------------------------------
	localparam int AW        = 6;
	localparam int DW        = 32;
	localparam int BLK_WORDS = 16;
	localparam int KEY_WORDS = 16;
	localparam int DIG_MAX   = 8;
	localparam logic [31:0] BLK_BYTES = 32'd64;
	localparam logic [31:0] PAD_ROOM  = 32'd56;
	// ----------------------------------------------------------
	// engine register indices (word addresses)
	// ----------------------------------------------------------
	localparam logic [AW-1:0] REG_DIGEST = 6'h00;
	localparam logic [AW-1:0] REG_DATA   = 6'h10;
	localparam logic [AW-1:0] REG_MODE   = 6'h20;
	localparam logic [AW-1:0] REG_LENGTH = 6'h21;
	localparam logic [AW-1:0] REG_RAW    = 6'h22;
	localparam logic [AW-1:0] REG_MASKED = 6'h23;
	localparam logic [AW-1:0] REG_IRQ_EN = 6'h24;
	localparam logic [AW-1:0] REG_SYSCFG = 6'h25;
	// ----------------------------------------------------------
	// mode fields, system config bits, flag bits
	// ----------------------------------------------------------
	localparam int MODE_W       = 5;
	localparam int MODE_HMAC    = 2;
	localparam int MODE_CLOSE   = 3;
	localparam int MODE_PPKEY   = 4;
	localparam logic [1:0] ALGO_MD5    = 2'h0;
	localparam logic [1:0] ALGO_SHA1   = 2'h1;
	localparam logic [1:0] ALGO_SHA224 = 2'h2;
	localparam logic [1:0] ALGO_SHA256 = 2'h3;
	localparam int CFG_SRST     = 0;
	localparam int CFG_DMA      = 1;
	localparam int NFLAG        = 4;
	localparam int FLG_CTX      = 0;
	localparam int FLG_PART     = 1;
	localparam int FLG_MSG      = 2;
	localparam int FLG_OUT      = 3;
	localparam logic [31:0] IPAD    = 32'h36363636;
	localparam logic [31:0] IV_BASE = 32'h01234567;
	localparam int ROUNDS = 16;

	// digest words per algorithm
	function automatic logic [3:0] hhe_dlen(input logic [1:0] algo);
		case (algo)
			ALGO_MD5:    hhe_dlen = 4'h4;
			ALGO_SHA1:   hhe_dlen = 4'h5;
			ALGO_SHA224: hhe_dlen = 4'h7;
			default:     hhe_dlen = 4'h8;
		endcase
	endfunction : hhe_dlen
endpackage : hhe_pkg

// ===== testbench/hhe_link_props.sv
/*
 * Checker on the link between controller and engine.
 * Assumes it is instantiated beside the link in the bench top.
 */
module hhe_link_props
	import hhe_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic [5:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        irq,
	input wire logic        dma_req
);
	logic [3:0] en_ff;
	logic [1:0] algo_ff;
	logic       dma_ff;
	logic [4:0] cnt_ff;
	logic [3:0] dlen;
	logic       dwr;

	// --------------------------------------------
	// shadow of what the controller wrote
	// --------------------------------------------
	assign dwr  = wr && addr[5:4] == 2'h1;
	assign dlen = algo_ff == 2'h0 ? 4'h4 : algo_ff == 2'h1 ? 4'h5 :
		algo_ff == 2'h2 ? 4'h7 : 4'h8;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) en_ff <= 4'h0;
		else if (wr && addr == REG_IRQ_EN) en_ff <= wdata[3:0];
	end
	always_ff @(posedge clk_in) begin
		if (!resetn_in) algo_ff <= 2'h0;
		else if (wr && addr == REG_MODE) algo_ff <= wdata[1:0];
	end
	always_ff @(posedge clk_in) begin
		if (!resetn_in) dma_ff <= 1'b0;
		else if (wr && addr == REG_SYSCFG) dma_ff <= wdata[CFG_DMA];
	end
	always_ff @(posedge clk_in) begin
		if (!resetn_in || (wr && addr == REG_LENGTH)) cnt_ff <= 5'h0;
		else if (dwr) cnt_ff <= cnt_ff + 5'h1;
	end

	// --------------------------------------------
	// properties
	// --------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_irq_gated: assert property (
		irq |-> $past(en_ff) != 4'h0)
		else $error("irq with every source disabled");
	a_masked_view: assert property (
		rd && addr == REG_MASKED |=> (rdata[3:0] & ~$past(en_ff)) == 4'h0)
		else $error("masked status shows a disabled source");
	a_digest_tail: assert property (
		rd && addr < REG_DATA && addr[3:0] >= dlen |=> rdata == 32'h0)
		else $error("digest word beyond length not zero");
	a_dma_gated: assert property (
		dma_req |-> $past(dma_ff))
		else $error("dma request while dma disabled");
	a_length_starts: assert property (
		wr && addr == REG_LENGTH && dma_ff |-> ##[1:40] dma_req)
		else $error("length write did not start the job");
	a_block_taken: assert property (
		dwr && cnt_ff == 5'hf |-> ##2 !dma_req [*4])
		else $error("dma request after a full block");
	a_digest_done: assert property (
		dwr && cnt_ff == 5'hf && en_ff[FLG_OUT] |-> ##[2:60] irq)
		else $error("no interrupt after final block");
	a_soft_reset: assert property (
		wr && addr == REG_SYSCFG && wdata[CFG_SRST] |-> ##3 !irq)
		else $error("irq survived soft reset");
endmodule : hhe_link_props

// ===== testbench/tb_hash_hmac_engine_control.sv
/*
 * Bench: controller and engine joined by the link, driven
 * through the controller's software port.
 * Assumes the controller's map: mode 0x00, length 0x01,
 * control 0x02, status 0x03, key 0x10, data 0x20, result 0x30.
 */
module tb_hash_hmac_engine_control;
	timeunit 1ns;
	timeprecision 1ps;
	import hhe_pkg::*;

	logic        clk_in    = 1'b0;
	logic        resetn_in = 1'b0;
	logic [5:0]  cmd_addr  = 6'h0;
	logic [31:0] cmd_wdata = 32'h0;
	logic        cmd_wr    = 1'b0;
	logic        cmd_rd    = 1'b0;
	logic [31:0] cmd_rdata;
	logic        busy;
	logic [2:0]  stat;
	logic [31:0] plain_w0;
	logic        busy_seen;
	int          polls;
	int          mismatches = 0;
	int          checks     = 0;

	always #12.5 clk_in = ~clk_in;

	hhe_link_if hhe_link_if_inst (.clk_in(clk_in));
	hhe_engine hhe_engine_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.link(hhe_link_if_inst.dev), .busy_out(busy));
	hhe_host hhe_host_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
		.cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
		.cmd_rdata_out(cmd_rdata), .link(hhe_link_if_inst.host));
	hhe_link_props hhe_link_props_inst (.clk_in(clk_in),
		.resetn_in(resetn_in), .addr(hhe_link_if_inst.addr),
		.wdata(hhe_link_if_inst.wdata), .wr(hhe_link_if_inst.wr),
		.rd(hhe_link_if_inst.rd), .rdata(hhe_link_if_inst.rdata),
		.irq(hhe_link_if_inst.irq), .dma_req(hhe_link_if_inst.dma_req));

	// --------------------------------------------
	// software port and judging
	// --------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic sw_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		cmd_addr  <= a;
		cmd_wdata <= d;
		cmd_wr    <= 1'b1;
		@(posedge clk_in);
		cmd_wr <= 1'b0;
	endtask : sw_wr

	task automatic sw_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk_in);
		cmd_addr <= a;
		cmd_rd   <= 1'b1;
		@(posedge clk_in);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask : sw_rd

	task automatic run_job(input logic [4:0] md, input logic [31:0] ln,
		input logic dma);
		logic [31:0] d;
		sw_wr(6'h00, {27'h0, md});
		sw_wr(6'h01, ln);
		for (int i = 0; i < 16; i++) begin
			sw_wr(6'(6'h10 + i), i < 4 ? 32'h6b650000 | i : 32'h0);
			sw_wr(6'(6'h20 + i), 32'hc0de0000 | i);
		end
		sw_wr(6'h02, {30'h0, dma, 1'b1});
		polls     = 0;
		busy_seen = 1'b0;
		do begin
			sw_rd(6'h03, d);
			polls++;
			if (busy === 1'b1) busy_seen = 1'b1;
		end while (d[2:1] === 2'b00 && polls < 400);
		stat = d[2:0];
	endtask : run_job

	task automatic read_dig(input logic [1:0] a, output logic [31:0] w0);
		logic [31:0] d;
		int          dl;
		dl = a == 2'h0 ? 4 : a == 2'h1 ? 5 : a == 2'h2 ? 7 : 8;
		for (int w = 0; w < 8; w++) begin
			sw_rd(6'(6'h30 + w), d);
			if (w == 0) w0 = d;
			if (w >= dl) chk("digest tail", d, 32'h0);
		end
	endtask : read_dig

	// --------------------------------------------
	// scenarios
	// --------------------------------------------
	task automatic t_algos();
		logic [31:0] w0;
		for (int a = 0; a < 4; a++) begin
			run_job({3'h0, 2'(a)}, 32'd64, 1'b0);
			chk("plain status", {29'h0, stat}, 32'h2);
			chk("engine ran", {31'h0, busy_seen}, 32'h1);
			chk("engine idle", {31'h0, busy}, 32'h0);
			read_dig(2'(a), w0);
			if (a == 1) plain_w0 = w0;
		end
	endtask : t_algos

	task automatic t_lengths();
		logic [4:0]  md [4] = '{5'h01, 5'h01, 5'h09, 5'h09};
		logic [31:0] ln [4] = '{32'd60, 32'd0, 32'd60, 32'd64};
		for (int i = 0; i < 4; i++) begin
			run_job(md[i], ln[i], 1'b0);
			chk("error bit", {31'h0, stat[2]}, {31'h0, ~md[i][3]});
			if (md[i][3]) chk("pad done", {31'h0, stat[1]}, 32'h1);
		end
	endtask : t_lengths

	task automatic t_keyed();
		logic [31:0] w0;
		int          n_raw;
		run_job(5'h05, 32'd64, 1'b1);
		n_raw = polls;
		chk("keyed status", {29'h0, stat}, 32'h2);
		read_dig(2'h1, w0);
		chk("keyed digest", {31'h0, w0 !== plain_w0}, 32'h1);
		run_job(5'h15, 32'd64, 1'b0);
		chk("pp status", {29'h0, stat}, 32'h2);
		chk("pp shorter", {31'h0, polls < n_raw}, 32'h1);
	endtask : t_keyed

	task automatic close_out();
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_algos();
		t_lengths();
		t_keyed();
		close_out();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		mismatches++;
		close_out();
	end
endmodule : tb_hash_hmac_engine_control
